// ### jtp_pkg.sv
/*
 Shared constants and types for the test access pin block.
 Assumes one system clock (core_clk); all test pins arrive asynchronously.
*/
package jtp_pkg;
   // -----------------------------------------------------------
   // TAP states
   // -----------------------------------------------------------
   typedef enum logic [3:0] {
      JTP_RESET   = 4'h0,
      JTP_IDLE    = 4'h1,
      JTP_SEL_DR  = 4'h2,
      JTP_CAP_DR  = 4'h3,
      JTP_SH_DR   = 4'h4,
      JTP_EX1_DR  = 4'h5,
      JTP_PA_DR   = 4'h6,
      JTP_EX2_DR  = 4'h7,
      JTP_UPD_DR  = 4'h8,
      JTP_SEL_IR  = 4'h9,
      JTP_CAP_IR  = 4'hA,
      JTP_SH_IR   = 4'hB,
      JTP_EX1_IR  = 4'hC,
      JTP_PA_IR   = 4'hD,
      JTP_EX2_IR  = 4'hE,
      JTP_UPD_IR  = 4'hF
   } jtp_state_e;

   // -----------------------------------------------------------
   // Register layout
   // -----------------------------------------------------------
   localparam int JTP_IR_W        = 4;
   localparam int JTP_DR_W        = 8;
   localparam logic [3:0] JTP_IR_RST     = 4'h1;
   localparam logic [3:0] JTP_IR_CAPTURE = 4'h1;
   // Instruction codes
   localparam logic [3:0] JTP_OP_BYPASS  = 4'hF;
   localparam logic [3:0] JTP_OP_USER    = 4'h2;
   localparam logic [3:0] JTP_OP_EMUCTL  = 4'h3;
   // Emulation control data bit positions
   localparam int JTP_EMU_OE_BIT  = 0;
   localparam int JTP_EMU_VAL_BIT = 1;
   localparam logic [7:0] JTP_DR_RST     = 8'h00;
   localparam logic [1:0] JTP_EMUCTL_RST = 2'h0;
endpackage

// ### jtp_sync.sv
/*
 Two flip-flop synchroniser, one per bit.
 Assumes input is asynchronous to clk.
*/
`timescale 1ns/1ps
module jtp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] out_d;

   always_comb begin
      meta_d = din;
      out_d  = meta_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= meta_d;
         dout   <= out_d;
      end
   end
endmodule

// ### jtp_top.sv
/*
 Test access pin logic: TAP controller, instruction and data registers,
 emulator event line 0 steering and boundary-scan latch.
 Assumes test pins are asynchronous; test clock far slower than core_clk.
*/
`timescale 1ns/1ps
module jtp_top (
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   input  wire logic                 test_rst,
   input  wire logic                 test_clk,
   input  wire logic                 test_mode_sel,
   input  wire logic                 test_data_in,
   output logic                      test_data_out,
   output logic                      test_data_out_oe,
   input  wire logic                 emulator_event_line_0_in,
   output logic                      emulator_event_line_0_out,
   output logic                      emulator_event_line_0_oe,
   input  wire logic                 emulator_event_line_1_in,
   input  wire logic                 dev_event_in,
   output logic                      emu_event_out,
   output logic                      scan_control,
   output logic                      boundary_scan_mode,
   output logic [jtp_pkg::JTP_DR_W-1:0] user_data
);
   import jtp_pkg::*;

   // -----------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------
   logic [5:0] pins_s;

   jtp_sync #(.W(6)) u_sync (
      .clk  (core_clk),
      .rst  (sys_rst),
      .din  ({test_rst, test_clk, test_mode_sel, test_data_in,
              emulator_event_line_0_in, emulator_event_line_1_in}),
      .dout (pins_s)
   );

   logic trst_s, tck_s, tms_s, tdi_s, emulator_event_line_0_s, emulator_event_line_1_s;
   assign trst_s = pins_s[5];
   assign tck_s  = pins_s[4];
   assign tms_s  = pins_s[3];
   assign tdi_s  = pins_s[2];
   assign emulator_event_line_0_s = pins_s[1];
   assign emulator_event_line_1_s = pins_s[0];

   // -----------------------------------------------------------
   // Edge detection
   // -----------------------------------------------------------
   logic tck_prev_q, tck_prev_d;
   logic trst_prev_q, trst_prev_d;
   logic tck_rise, tck_fall, trst_rise;

   always_comb begin
      tck_prev_d  = tck_s;
      trst_prev_d = trst_s;
      tck_rise    = tck_s & ~tck_prev_q;
      tck_fall    = ~tck_s & tck_prev_q;
      trst_rise   = trst_s & ~trst_prev_q;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tck_prev_q  <= 1'b0;
         trst_prev_q <= 1'b0;
      end else begin
         tck_prev_q  <= tck_prev_d;
         trst_prev_q <= trst_prev_d;
      end
   end

   // -----------------------------------------------------------
   // TAP controller
   // -----------------------------------------------------------
   jtp_state_e state_q, state_d;
   logic [JTP_IR_W-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
   logic [JTP_DR_W-1:0] dr_sh_q, dr_sh_d, udr_q, udr_d;
   logic [1:0]          emuctl_q, emuctl_d;
   logic                byp_q, byp_d;
   logic                tdo_q, tdo_d, oe_q, oe_d;
   logic                shifting;
   logic                sel_out;

   always_comb begin
      state_d = state_q;
      if (!trst_s) begin
         state_d = JTP_RESET;
      end else if (tck_rise) begin
         case (state_q)
            JTP_RESET:  state_d = tms_s ? JTP_RESET  : JTP_IDLE;
            JTP_IDLE:   state_d = tms_s ? JTP_SEL_DR : JTP_IDLE;
            JTP_SEL_DR: state_d = tms_s ? JTP_SEL_IR : JTP_CAP_DR;
            JTP_CAP_DR: state_d = tms_s ? JTP_EX1_DR : JTP_SH_DR;
            JTP_SH_DR:  state_d = tms_s ? JTP_EX1_DR : JTP_SH_DR;
            JTP_EX1_DR: state_d = tms_s ? JTP_UPD_DR : JTP_PA_DR;
            JTP_PA_DR:  state_d = tms_s ? JTP_EX2_DR : JTP_PA_DR;
            JTP_EX2_DR: state_d = tms_s ? JTP_UPD_DR : JTP_SH_DR;
            JTP_UPD_DR: state_d = tms_s ? JTP_SEL_DR : JTP_IDLE;
            JTP_SEL_IR: state_d = tms_s ? JTP_RESET  : JTP_CAP_IR;
            JTP_CAP_IR: state_d = tms_s ? JTP_EX1_IR : JTP_SH_IR;
            JTP_SH_IR:  state_d = tms_s ? JTP_EX1_IR : JTP_SH_IR;
            JTP_EX1_IR: state_d = tms_s ? JTP_UPD_IR : JTP_PA_IR;
            JTP_PA_IR:  state_d = tms_s ? JTP_EX2_IR : JTP_PA_IR;
            JTP_EX2_IR: state_d = tms_s ? JTP_UPD_IR : JTP_SH_IR;
            JTP_UPD_IR: state_d = tms_s ? JTP_SEL_DR : JTP_IDLE;
            default:    state_d = JTP_RESET;
         endcase
      end
   end

   // -----------------------------------------------------------
   // Shift registers
   // -----------------------------------------------------------
   always_comb begin
      ir_sh_d  = ir_sh_q;
      ir_d     = ir_q;
      dr_sh_d  = dr_sh_q;
      udr_d    = udr_q;
      emuctl_d = emuctl_q;
      byp_d    = byp_q;
      if (!trst_s || state_q == JTP_RESET) begin
         ir_d     = JTP_IR_RST;
         emuctl_d = JTP_EMUCTL_RST;
      end else if (tck_rise) begin
         case (state_q)
            JTP_CAP_IR: ir_sh_d = JTP_IR_CAPTURE;
            JTP_SH_IR:  ir_sh_d = {tdi_s, ir_sh_q[JTP_IR_W-1:1]};
            JTP_UPD_IR: ir_d    = ir_sh_q;
            JTP_CAP_DR: begin
               dr_sh_d = (ir_q == JTP_OP_EMUCTL) ?
                         {6'h00, emulator_event_line_0_s, emuctl_q[JTP_EMU_OE_BIT]} : udr_q;
               byp_d   = 1'b0;
            end
            JTP_SH_DR: begin
               dr_sh_d = {tdi_s, dr_sh_q[JTP_DR_W-1:1]};
               byp_d   = tdi_s;
            end
            JTP_UPD_DR: begin
               if (ir_q == JTP_OP_USER)
                  udr_d = dr_sh_q;
               if (ir_q == JTP_OP_EMUCTL)
                  emuctl_d = dr_sh_q[1:0];
            end
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------
   // Data output: updated on falling test clock
   // -----------------------------------------------------------
   always_comb begin
      shifting = (state_q == JTP_SH_DR) || (state_q == JTP_SH_IR);
      if (state_q == JTP_SH_IR)
         sel_out = ir_sh_q[0];
      else if (ir_q == JTP_OP_BYPASS)
         sel_out = byp_q;
      else
         sel_out = dr_sh_q[0];
      tdo_d = tdo_q;
      oe_d  = oe_q;
      if (!trst_s) begin
         oe_d = 1'b0;
      end else if (tck_fall) begin
         tdo_d = sel_out;
         oe_d  = shifting;
      end
   end

   // -----------------------------------------------------------
   // Boundary-scan latch
   // -----------------------------------------------------------
   logic bscan_q, bscan_d;

   always_comb begin
      bscan_d = bscan_q;
      if (trst_rise && emulator_event_line_0_s && !emulator_event_line_1_s)
         bscan_d = 1'b1;
      else if (!trst_s)
         bscan_d = 1'b0;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q  <= JTP_RESET;
         ir_sh_q  <= JTP_IR_RST;
         ir_q     <= JTP_IR_RST;
         dr_sh_q  <= JTP_DR_RST;
         udr_q    <= JTP_DR_RST;
         emuctl_q <= JTP_EMUCTL_RST;
         byp_q    <= 1'b0;
         tdo_q    <= 1'b0;
         oe_q     <= 1'b0;
         bscan_q  <= 1'b0;
      end else begin
         state_q  <= state_d;
         ir_sh_q  <= ir_sh_d;
         ir_q     <= ir_d;
         dr_sh_q  <= dr_sh_d;
         udr_q    <= udr_d;
         emuctl_q <= emuctl_d;
         byp_q    <= byp_d;
         tdo_q    <= tdo_d;
         oe_q     <= oe_d;
         bscan_q  <= bscan_d;
      end
   end

   // -----------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------
   logic ev_q, ev_d;

   always_comb begin
      ev_d = trst_s & ~emuctl_q[JTP_EMU_OE_BIT] & emulator_event_line_0_s;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst)
         ev_q <= 1'b0;
      else
         ev_q <= ev_d;
   end

   assign test_data_out             = tdo_q;
   assign test_data_out_oe          = oe_q;
   assign scan_control              = trst_s;
   assign boundary_scan_mode        = bscan_q;
   assign emulator_event_line_0_oe  = trst_s & emuctl_q[JTP_EMU_OE_BIT];
   assign emulator_event_line_0_out = emuctl_q[JTP_EMU_VAL_BIT] | dev_event_in;
   assign emu_event_out             = ev_q;
   assign user_data                 = udr_q;
endmodule

// ### jtp_asserts.sv
/*
 Checker for the test access pins: scan control, data output and line 0.
 Bound into jtp_top; sees only that module's ports.
*/
`timescale 1ns/1ps
module jtp_asserts (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic test_rst,
   input wire logic test_clk,
   input wire logic test_data_out,
   input wire logic test_data_out_oe,
   input wire logic emulator_event_line_0_in,
   input wire logic emulator_event_line_0_oe,
   input wire logic emulator_event_line_1_in,
   input wire logic scan_control,
   input wire logic boundary_scan_mode
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_scan_taken: assert property (test_rst [*3] |-> scan_control)
      else $error("scan control not taken");
   a_scan_left: assert property (!test_rst [*3] |-> !scan_control)
      else $error("scan control held in functional mode");
   a_tdo_quiet: assert property (!scan_control [*2] |->
      !test_data_out_oe)
      else $error("data output driven in functional mode");
   a_line0_off: assert property (!scan_control [*2] |->
      !emulator_event_line_0_oe)
      else $error("line 0 driven in functional mode");
   a_tdo_fall: assert property ($changed(test_data_out) &&
      test_data_out_oe |-> !test_clk && !$past(test_clk))
      else $error("data output moved outside low clock phase");
   a_oe_fall: assert property ($rose(test_data_out_oe) |-> !test_clk)
      else $error("output enable rose outside low clock phase");
   a_bscan_set: assert property ($rose(test_rst) &&
      emulator_event_line_0_in && !emulator_event_line_1_in
      |-> ##[1:8] boundary_scan_mode)
      else $error("boundary scan not latched");
   a_bscan_stand: assert property (boundary_scan_mode &&
      scan_control |=> boundary_scan_mode)
      else $error("boundary scan dropped");
   a_bscan_cause: assert property ($rose(boundary_scan_mode) |->
      scan_control && !emulator_event_line_1_in)
      else $error("boundary scan without cause");
endmodule
bind jtp_top jtp_asserts chk_u (
   .core_clk                 (core_clk),
   .sys_rst                  (sys_rst),
   .test_rst                 (test_rst),
   .test_clk                 (test_clk),
   .test_data_out            (test_data_out),
   .test_data_out_oe         (test_data_out_oe),
   .emulator_event_line_0_in (emulator_event_line_0_in),
   .emulator_event_line_0_oe (emulator_event_line_0_oe),
   .emulator_event_line_1_in (emulator_event_line_1_in),
   .scan_control             (scan_control),
   .boundary_scan_mode       (boundary_scan_mode)
);

// ### jtp_emu.sv
/*
 Scan host model: drives test clock, mode select and data input.
 Assumes tdo_w is the resolved data output wire.
*/
`timescale 1ns/1ps
module jtp_emu (
   input  wire logic core_clk,
   input  wire logic tdo_w,
   output logic      test_clk,
   output logic      test_mode_sel,
   output logic      test_data_in
);
   logic tdo_bit;
   // Pull-up levels while idle
   initial begin
      test_clk = 1'b1;
      test_mode_sel = 1'b1;
      test_data_in = 1'b1;
   end
   // ------------------------------------------------------------
   // One test clock period, 160 ns
   // ------------------------------------------------------------
   task automatic tap(input logic m, input logic d);
      test_clk <= 1'b0;
      test_mode_sel <= m;
      test_data_in <= d;
      repeat (4) @(posedge core_clk);
      tdo_bit = tdo_w;
      test_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask
   // From idle through one shift, back to idle, LSB first
   task automatic scan(input logic ir, input logic [7:0] v,
                       output logic [7:0] q);
      int n;
      n = ir ? 4 : 8;
      q = 8'h00;
      tap(1'b1, 1'b0);
      if (ir) tap(1'b1, 1'b0);
      tap(1'b0, 1'b0);
      tap(1'b0, 1'b0);
      for (int i = 0; i < n; i++) begin
         tap(i == n - 1, v[i]);
         q[i] = tdo_bit;
      end
      tap(1'b1, 1'b0);
      tap(1'b0, 1'b0);
   endtask
endmodule

// ### jtp_top_tb.sv
/*
 Testbench for jtp_top with the scan host model.
 Assumes a 50 MHz core_clk and pull-ups on line 0 and line 1.
*/
`timescale 1ns/1ps
module jtp_top_tb;
   import jtp_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1, test_rst = 1'b0;
   logic emulator_event_line_1_in = 1'b1, dev_event_in = 1'b0;
   logic emu_drv = 1'b1;
   logic test_clk, test_mode_sel, test_data_in, test_data_out;
   logic test_data_out_oe, emulator_event_line_0_out;
   logic emulator_event_line_0_oe, emu_event_out, scan_control;
   logic boundary_scan_mode, emulator_event_line_0_in, tdo_w;
   logic [JTP_DR_W-1:0] user_data;
   logic [7:0] q;
   int fails = 0, cmp_count = 0, cyc = 0;
   assign emulator_event_line_0_in = emulator_event_line_0_oe ?
                                     emulator_event_line_0_out : emu_drv;
   // Released data output shows the inverse of its last value
   assign tdo_w = test_data_out_oe ? test_data_out : ~test_data_out;
   jtp_top dut_u (
      .core_clk                  (core_clk),
      .sys_rst                   (sys_rst),
      .test_rst                  (test_rst),
      .test_clk                  (test_clk),
      .test_mode_sel             (test_mode_sel),
      .test_data_in              (test_data_in),
      .test_data_out             (test_data_out),
      .test_data_out_oe          (test_data_out_oe),
      .emulator_event_line_0_in  (emulator_event_line_0_in),
      .emulator_event_line_0_out (emulator_event_line_0_out),
      .emulator_event_line_0_oe  (emulator_event_line_0_oe),
      .emulator_event_line_1_in  (emulator_event_line_1_in),
      .dev_event_in              (dev_event_in),
      .emu_event_out             (emu_event_out),
      .scan_control              (scan_control),
      .boundary_scan_mode        (boundary_scan_mode),
      .user_data                 (user_data)
   );
   jtp_emu emu_u (.core_clk, .tdo_w, .test_clk, .test_mode_sel,
                  .test_data_in);
   // ------------------------------------------------------------
   // Clock, timeout, compare and report
   // ------------------------------------------------------------
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         stop_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_enter(input logic l1);
      emulator_event_line_1_in <= l1;
      @(posedge core_clk);
      test_rst <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk({7'h0, scan_control}, 8'h01);
      chk({7'h0, boundary_scan_mode}, {7'h0, !l1});
      emu_u.tap(1'b0, 1'b0);
   endtask
   task automatic t_regs;
      emu_u.scan(1'b1, {4'h0, JTP_OP_USER}, q);
      chk({4'h0, q[3:0]}, {4'h0, JTP_IR_CAPTURE});
      emu_u.scan(1'b0, 8'hA5, q);
      chk(user_data, 8'hA5);
      emu_u.scan(1'b1, {4'h0, JTP_OP_BYPASS}, q);
      emu_u.scan(1'b0, 8'h5A, q);
      chk(q, 8'hB4);
      chk({7'h0, test_data_out_oe}, 8'h00);
   endtask
   task automatic t_emu;
      emu_u.scan(1'b1, {4'h0, JTP_OP_EMUCTL}, q);
      emu_u.scan(1'b0, 8'h03, q);
      chk({6'h0, emulator_event_line_0_oe, emulator_event_line_0_in},
          8'h03);
      emu_u.scan(1'b0, 8'h00, q);
      chk(q, 8'h03);
      dev_event_in <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk({6'h0, emulator_event_line_0_oe, emulator_event_line_0_out},
          8'h01);
      chk({7'h0, emu_event_out}, 8'h01);
      dev_event_in <= 1'b0;
      emu_drv      <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk({7'h0, emu_event_out}, 8'h00);
      emu_drv      <= 1'b1;
   endtask
   task automatic t_func;
      test_rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      emu_u.scan(1'b1, {4'h0, JTP_OP_USER}, q);
      emu_u.scan(1'b0, 8'h3C, q);
      chk({7'h0, scan_control}, 8'h00);
      chk(user_data, 8'hA5);
      chk({6'h0, test_data_out_oe, emulator_event_line_0_oe},
          8'h00);
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      t_enter(1'b1);
      t_regs();
      t_emu();
      t_func();
      t_enter(1'b0);
      stop_test();
   end
endmodule
